// >>> rtl/general_purpose_pin_control.sv
// Four general-purpose pins: direction, input and output functions,
// general input/output values and clock output enable steering.
// Assumes a byte-wide register port on mclk and PLL status on mclk.
`timescale 1ns/1ps

module general_purpose_pin_control
   import gpio_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire reg_req_t             reg_req,
   output      logic [DATA_W-1:0]    reg_rdata,
   input  wire logic [PIN_COUNT-1:0] pin_in,
   output      logic [PIN_COUNT-1:0] pin_out,
   output      logic [PIN_COUNT-1:0] pin_oe_n,
   input  wire pll_status_t          pll_status,
   input  wire logic [CLK_OUTS-1:0]  clock_output_enable,
   output      logic [CLK_OUTS-1:0]  clock_output_active,
   output      logic [CLK_OUTS-1:0]  clock_output_hiz,
   output      logic                 manual_reference_select,
   output      logic                 manual_reference_select_valid
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [PIN_COUNT-1:0] dir_q;
   logic [PIN_COUNT-1:0] in_b2_q;
   logic [PIN_COUNT-1:0] in_b1_q;
   logic [PIN_COUNT-1:0] in_b0_q;
   logic [PIN_COUNT-1:0] out_b2_q;
   logic [PIN_COUNT-1:0] out_b1_q;
   logic [PIN_COUNT-1:0] out_b0_q;
   logic [PIN_COUNT-1:0] gen_out_q;
   logic [DATA_W-1:0]    rdata_q;
   logic [DATA_W-1:0]    rdata_d;
   logic [PIN_COUNT-1:0] sync1_q;
   logic [PIN_COUNT-1:0] sync2_q;

   // Gathers one pin's three-bit code from the bit-sliced registers
   function automatic logic [CODE_W-1:0] pick_code(
      input logic [PIN_COUNT-1:0] b2,
      input logic [PIN_COUNT-1:0] b1,
      input logic [PIN_COUNT-1:0] b0,
      input int                   idx
   );
      pick_code = {b2[idx], b1[idx], b0[idx]};
   endfunction : pick_code

   // Widens a pin field into a read byte, upper bits zero
   function automatic logic [DATA_W-1:0] as_byte(
      input logic [PIN_COUNT-1:0] v
   );
      as_byte = {{(DATA_W-PIN_COUNT){1'b0}}, v};
   endfunction : as_byte

   // Marks the pins whose three-bit code equals one function
   function automatic logic [PIN_COUNT-1:0] code_mask(
      input logic [PIN_COUNT-1:0] b2,
      input logic [PIN_COUNT-1:0] b1,
      input logic [PIN_COUNT-1:0] b0,
      input logic [CODE_W-1:0]    fn
   );
      code_mask = '0;
      for (int p = 0; p < PIN_COUNT; p++)
         code_mask[p] = pick_code(b2, b1, b0, p) == fn;
   endfunction : code_mask

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire wr_dir     = reg_req.wr && reg_req.addr == OFS_PIN_DIRECTION;
   wire wr_in_b2   = reg_req.wr && reg_req.addr == OFS_IN_FUNC_BIT2;
   wire wr_in_b1   = reg_req.wr && reg_req.addr == OFS_IN_FUNC_BIT1;
   wire wr_in_b0   = reg_req.wr && reg_req.addr == OFS_IN_FUNC_BIT0;
   wire wr_out_b2  = reg_req.wr && reg_req.addr == OFS_OUT_FUNC_BIT2;
   wire wr_out_b1  = reg_req.wr && reg_req.addr == OFS_OUT_FUNC_BIT1;
   wire wr_out_b0  = reg_req.wr && reg_req.addr == OFS_OUT_FUNC_BIT0;
   wire wr_gen_out = reg_req.wr && reg_req.addr == OFS_GEN_OUT_VALUE;
   wire [PIN_COUNT-1:0] wfield = reg_req.wdata[PIN_COUNT-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, one short block per register; upper bits are discarded
   always_ff @(posedge mclk)
   begin
      if (rst)
         dir_q <= RST_PIN_FIELD;
      else if (wr_dir)
         dir_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         in_b2_q <= RST_PIN_FIELD;
      else if (wr_in_b2)
         in_b2_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         in_b1_q <= RST_PIN_FIELD;
      else if (wr_in_b1)
         in_b1_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         in_b0_q <= RST_PIN_FIELD;
      else if (wr_in_b0)
         in_b0_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         out_b2_q <= RST_PIN_FIELD;
      else if (wr_out_b2)
         out_b2_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         out_b1_q <= RST_PIN_FIELD;
      else if (wr_out_b1)
         out_b1_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         out_b0_q <= RST_PIN_FIELD;
      else if (wr_out_b0)
         out_b0_q <= wfield;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         gen_out_q <= RST_PIN_FIELD;
      else if (wr_gen_out)
         gen_out_q <= wfield;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronizer; first stage feeds only the second
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1_q <= RST_PIN_FIELD;
         sync2_q <= RST_PIN_FIELD;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin function decode
   logic [PIN_COUNT-1:0] is_in;
   logic [PIN_COUNT-1:0] gen_in_mask;
   logic [PIN_COUNT-1:0] oe_sel_a;
   logic [PIN_COUNT-1:0] oe_sel_b;
   logic [PIN_COUNT-1:0] drive_val;
   logic [PIN_COUNT-1:0] drives;
   logic                 ref_sel_in;
   logic                 ref_sel_out;

   wire [PIN_COUNT-1:0] in_general =
      code_mask(in_b2_q, in_b1_q, in_b0_q, FN_GENERAL);
   wire [PIN_COUNT-1:0] in_sel_a =
      code_mask(in_b2_q, in_b1_q, in_b0_q, FN_SEL_A);
   wire [PIN_COUNT-1:0] in_sel_b =
      code_mask(in_b2_q, in_b1_q, in_b0_q, FN_SEL_B);

   assign is_in       = ~dir_q;
   assign gen_in_mask = is_in & in_general;
   assign oe_sel_a    = is_in & in_sel_a;
   assign oe_sel_b    = is_in & in_sel_b;

   // Pin 2 as reference select, from either direction's code
   assign ref_sel_in  = is_in[REF_SEL_PIN] &&
      pick_code(in_b2_q, in_b1_q, in_b0_q, REF_SEL_PIN) == FN_REF_SELECT;
   assign ref_sel_out = !is_in[REF_SEL_PIN] &&
      pick_code(out_b2_q, out_b1_q, out_b0_q, REF_SEL_PIN)
         == FN_REF_SELECT;

   ////////////////////////////////////////////////////////////////////////////
   // Output function selection; reserved codes drive low
   wire [CODE_W-1:0] oc0 = pick_code(out_b2_q, out_b1_q, out_b0_q, 0);
   wire [CODE_W-1:0] oc1 = pick_code(out_b2_q, out_b1_q, out_b0_q, 1);
   wire [CODE_W-1:0] oc2 = pick_code(out_b2_q, out_b1_q, out_b0_q, 2);
   wire [CODE_W-1:0] oc3 = pick_code(out_b2_q, out_b1_q, out_b0_q, 3);

   assign drive_val[0] = (oc0 == FN_GENERAL) ? gen_out_q[0] :
                         (oc0 == FN_SEL_A) ? pll_status.loss_of_lock
                         : 1'b0;
   assign drive_val[1] = (oc1 == FN_GENERAL) ? gen_out_q[1] :
                         (oc1 == FN_SEL_A) ? pll_status.holdover
                         : 1'b0;
   assign drive_val[2] = (oc2 == FN_GENERAL) ? gen_out_q[2] :
      (oc2 == FN_SEL_A) ? pll_status.reference_signal_loss[0] :
      (oc2 == FN_SEL_B) ? pll_status.reference_signal_loss[1] :
      1'b0;
   assign drive_val[3] = (oc3 == FN_GENERAL) ? gen_out_q[3] :
      (oc3 == FN_SEL_B) ? pll_status.reference_signal_loss[1]
      : 1'b0;

   // Select code in output mode releases pin 2 so it can be sensed
   always_comb
   begin
      drives = dir_q;
      drives[REF_SEL_PIN] = dir_q[REF_SEL_PIN] && !ref_sel_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock output enable steering
   logic [CLK_OUTS-1:0] pin_gate;

   always_comb
   begin
      pin_gate = '1;
      for (int p = 0; p < PIN_COUNT; p++)
      begin
         if (oe_sel_a[p]) pin_gate[p] = sync2_q[p];
         if (oe_sel_b[p]) pin_gate[p + PIN_COUNT] = sync2_q[p];
      end
   end

   logic [CLK_OUTS-1:0]  active_q;
   logic [CLK_OUTS-1:0]  hiz_q;
   logic [PIN_COUNT-1:0] pin_out_q;
   logic [PIN_COUNT-1:0] oe_n_q;
   logic                 ref_sel_q;
   logic                 ref_valid_q;

   wire [CLK_OUTS-1:0] active_d    = clock_output_enable & pin_gate;
   wire                ref_valid_d = ref_sel_in || ref_sel_out;

   // Registered outputs keep pin and enable changes glitch free
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pin_out_q <= RST_PIN_FIELD;
         oe_n_q    <= ~RST_PIN_FIELD;
      end
      else
      begin
         pin_out_q <= drive_val & drives;
         oe_n_q    <= ~drives;
      end
   end

   // Both views of an enable come from flops, never from a gate
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         active_q <= '0;
         hiz_q    <= '1;
      end
      else
      begin
         active_q <= active_d;
         hiz_q    <= ~active_d;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ref_sel_q   <= 1'b0;
         ref_valid_q <= 1'b0;
      end
      else
      begin
         ref_sel_q   <= sync2_q[REF_SEL_PIN] && ref_valid_d;
         ref_valid_q <= ref_valid_d;
      end
   end

   assign clock_output_active           = active_q;
   assign clock_output_hiz              = hiz_q;
   assign pin_out                       = pin_out_q;
   assign pin_oe_n                      = oe_n_q;
   assign manual_reference_select       = ref_sel_q;
   assign manual_reference_select_valid = ref_valid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read path; reserved bits and unmapped addresses read zero
   wire [PIN_COUNT-1:0] gen_in_val = sync2_q & gen_in_mask;

   always_comb
   begin
      case (reg_req.addr)
         OFS_PIN_DIRECTION: rdata_d = as_byte(dir_q);
         OFS_IN_FUNC_BIT2:  rdata_d = as_byte(in_b2_q);
         OFS_IN_FUNC_BIT1:  rdata_d = as_byte(in_b1_q);
         OFS_IN_FUNC_BIT0:  rdata_d = as_byte(in_b0_q);
         OFS_OUT_FUNC_BIT2: rdata_d = as_byte(out_b2_q);
         OFS_OUT_FUNC_BIT1: rdata_d = as_byte(out_b1_q);
         OFS_OUT_FUNC_BIT0: rdata_d = as_byte(out_b0_q);
         OFS_GEN_OUT_VALUE: rdata_d = as_byte(gen_out_q);
         OFS_GEN_IN_VALUE:  rdata_d = as_byte(gen_in_val);
         default:           rdata_d = RST_READ_DATA;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         rdata_q <= RST_READ_DATA;
      else if (reg_req.rd)
         rdata_q <= rdata_d;
   end

   assign reg_rdata = rdata_q;

endmodule : general_purpose_pin_control

// >>> rtl/gpio_pkg.sv
// Constants and carrier types for the general-purpose pin control block.
// Assumes byte-wide register access with addresses up to 16 bits.
package gpio_pkg;

   localparam int          PIN_COUNT    = 4;
   localparam int          CLK_OUTS     = 8;
   localparam int          ADDR_W       = 16;
   localparam int          DATA_W       = 8;
   localparam int          CODE_W       = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [15:0] OFS_PIN_DIRECTION  = 16'h006E;
   localparam logic [15:0] OFS_IN_FUNC_BIT2   = 16'h006F;
   localparam logic [15:0] OFS_IN_FUNC_BIT1   = 16'h0070;
   localparam logic [15:0] OFS_IN_FUNC_BIT0   = 16'h0071;
   localparam logic [15:0] OFS_OUT_FUNC_BIT2  = 16'h0072;
   localparam logic [15:0] OFS_OUT_FUNC_BIT1  = 16'h0073;
   localparam logic [15:0] OFS_OUT_FUNC_BIT0  = 16'h0074;
   localparam logic [15:0] OFS_SPARE_BYTE     = 16'h0075;
   localparam logic [15:0] OFS_GEN_OUT_VALUE  = 16'h0076;
   localparam logic [15:0] OFS_GEN_IN_VALUE   = 16'h0219;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [3:0]  RST_PIN_FIELD      = 4'h0;
   localparam logic [7:0]  RST_READ_DATA      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Function codes
   localparam logic [2:0]  FN_GENERAL         = 3'h0;
   localparam logic [2:0]  FN_SEL_A           = 3'h1;
   localparam logic [2:0]  FN_SEL_B           = 3'h2;
   localparam logic [2:0]  FN_REF_SELECT      = 3'h5;

   // Pin that can carry the manual reference select
   localparam int          REF_SEL_PIN        = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic       loss_of_lock;
      logic       holdover;
      logic [1:0] reference_signal_loss;
   } pll_status_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } reg_req_t;

endpackage : gpio_pkg

// >>> tb/general_purpose_pin_control_tb.sv
// Self-checking bench for the pin control block.
// Assumes gpio_pkg, the design, the board model and the checker.
`timescale 1ns/1ps

module general_purpose_pin_control_tb;
   import gpio_pkg::*;
   logic mclk = 0, rst = 1, msel, msel_v;
   reg_req_t req = '0;
   pll_status_t st = '0;
   logic [7:0] rdata, clk_en = 8'h00, active, hiz;
   logic [3:0] pin_in, pin_out, pin_oe_n, board = 4'h0;
   int err_count = 0, n_checks = 0;

   always #5 mclk = ~mclk;

   general_purpose_pin_control dut (.mclk(mclk), .rst(rst), .reg_req(req),
      .reg_rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pll_status(st), .clock_output_enable(clk_en),
      .clock_output_active(active), .clock_output_hiz(hiz),
      .manual_reference_select(msel),
      .manual_reference_select_valid(msel_v));
   gpio_board_model board_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .board_level(board), .pin_in(pin_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // Software keeps reserved bits zero and never writes reserved codes
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      tick(1);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      tick(1);
      req.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      tick(1);
      req.addr = a;
      req.rd = 1'b1;
      tick(1);
      req.rd = 1'b0;
      chk(rdata, exp);
   endtask : rd
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(10);
      rst = 1'b0;
      for (int a = OFS_PIN_DIRECTION; a <= OFS_GEN_OUT_VALUE; a++)
         rd(16'(a), 8'h00);
      $display("reset values done");
      board = 4'hA;
      tick(4);
      rd(OFS_GEN_IN_VALUE, 8'h0A);
      wr(OFS_GEN_IN_VALUE, 8'h05);
      rd(OFS_GEN_IN_VALUE, 8'h0A);
      $display("general input done");
      wr(OFS_PIN_DIRECTION, 8'h0F);
      wr(OFS_GEN_OUT_VALUE, 8'h05);
      tick(2);
      chk({pin_oe_n, pin_out}, 8'h05);
      rd(OFS_GEN_IN_VALUE, 8'h00);
      wr(OFS_OUT_FUNC_BIT0, 8'h07);
      wr(OFS_OUT_FUNC_BIT1, 8'h08);
      st = 4'hA;
      tick(2);
      chk({4'h0, pin_out}, 8'h09);
      st = 4'h5;
      tick(2);
      chk({4'h0, pin_out}, 8'h06);
      wr(OFS_OUT_FUNC_BIT0, 8'h03);
      wr(OFS_OUT_FUNC_BIT1, 8'h0C);
      st = 4'hE;
      tick(2);
      chk({4'h0, pin_out}, 8'h0F);
      st = 4'hD;
      tick(2);
      chk({4'h0, pin_out}, 8'h03);
      $display("output functions done");
      board = 4'h4;
      wr(OFS_OUT_FUNC_BIT1, 8'h00);
      wr(OFS_OUT_FUNC_BIT0, 8'h04);
      wr(OFS_OUT_FUNC_BIT2, 8'h04);
      tick(4);
      chk({pin_oe_n, 2'h0, msel_v, msel}, 8'h43);
      $display("output select done");
      wr(OFS_OUT_FUNC_BIT2, 8'h00);
      wr(OFS_PIN_DIRECTION, 8'h00);
      clk_en = 8'hFF;
      board = 4'h5;
      wr(OFS_IN_FUNC_BIT0, 8'h0F);
      tick(4);
      chk(active, 8'hF5);
      chk(hiz, 8'h0A);
      wr(OFS_IN_FUNC_BIT0, 8'h04);
      wr(OFS_IN_FUNC_BIT1, 8'h0B);
      wr(OFS_IN_FUNC_BIT2, 8'h04);
      tick(4);
      chk({active[7:4], 2'h0, msel_v, msel}, 8'h53);
      clk_en = 8'h00;
      tick(2);
      chk(hiz, 8'hFF);
      $display("input functions done");
      close_out();
   end

   // Whole sequence needs under a hundred cycles
   initial
   begin
      #200us;
      err_count++;
      close_out();
   end
endmodule : general_purpose_pin_control_tb

bind general_purpose_pin_control gpio_pin_assertions u_chk (.mclk(mclk),
   .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pll_status(pll_status),
   .clock_output_enable(clock_output_enable),
   .clock_output_active(clock_output_active),
   .clock_output_hiz(clock_output_hiz),
   .manual_reference_select(manual_reference_select),
   .manual_reference_select_valid(manual_reference_select_valid));

// >>> tb/gpio_board_model.sv
// Board side of the four pins: resolves each wire from both drivers.
// Assumes the board always drives a released pin with board_level.
`timescale 1ns/1ps

module gpio_board_model
(
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe_n,
   input  wire logic [3:0] board_level,
   output wire logic [3:0] pin_in
);
   // Device wins where it drives; board fills released pins
   assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule : gpio_board_model

// >>> tb/gpio_pin_assertions.sv
// Port-level checks for the general-purpose pin control block.
// Assumes a bind onto general_purpose_pin_control, one clock domain.
`timescale 1ns/1ps

module gpio_pin_assertions
   import gpio_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire reg_req_t              reg_req,
   input wire logic [DATA_W-1:0]     reg_rdata,
   input wire logic [PIN_COUNT-1:0]  pin_in,
   input wire logic [PIN_COUNT-1:0]  pin_out,
   input wire logic [PIN_COUNT-1:0]  pin_oe_n,
   input wire pll_status_t           pll_status,
   input wire logic [CLK_OUTS-1:0]   clock_output_enable,
   input wire logic [CLK_OUTS-1:0]   clock_output_active,
   input wire logic [CLK_OUTS-1:0]   clock_output_hiz,
   input wire logic                  manual_reference_select,
   input wire logic                  manual_reference_select_valid
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   sequence s_dir_wr;
      reg_req.wr && reg_req.addr == OFS_PIN_DIRECTION;
   endsequence
   sequence s_dir_quiet;
      !(reg_req.wr && reg_req.addr == OFS_PIN_DIRECTION);
   endsequence

   // Pins 2 and 3 left out: pin 2 may release under the select code
   property p_dir_oe;
      s_dir_wr ##1 s_dir_quiet |=>
         pin_oe_n[1:0] == ~$past(reg_req.wdata[1:0], 2);
   endproperty
   property p_release_low;
      (pin_out & pin_oe_n) == 4'h0;
   endproperty
   property p_hiz;
      clock_output_hiz == ~clock_output_active;
   endproperty
   property p_enable_gate;
      1 |=> (clock_output_active & ~$past(clock_output_enable)) == 8'h00;
   endproperty
   property p_ref_idle;
      !manual_reference_select_valid |-> !manual_reference_select;
   endproperty
   property p_ref_released;
      manual_reference_select_valid |-> pin_oe_n[REF_SEL_PIN];
   endproperty
   property p_rdata_hold;
      !reg_req.rd |=> $stable(reg_rdata);
   endproperty
   property p_rdata_upper;
      reg_req.rd |=> reg_rdata[7:4] == 4'h0;
   endproperty

   a_dir_oe: assert property (p_dir_oe)
      else $error("direction write not seen on output enables");
   a_release_low: assert property (p_release_low)
      else $error("released pin has nonzero drive value");
   a_hiz: assert property (p_hiz)
      else $error("high impedance flag disagrees with enable");
   a_enable_gate: assert property (p_enable_gate)
      else $error("clock output active while its enable was low");
   a_ref_idle: assert property (p_ref_idle)
      else $error("reference select set without its function");
   a_ref_released: assert property (p_ref_released)
      else $error("reference select pin is being driven");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");
   a_rdata_upper: assert property (p_rdata_upper)
      else $error("upper read bits not zero");
endmodule : gpio_pin_assertions
